// file: irs_master_model.sv
// Purpose: Behavioural two-wire bus master
// Assumes: Link clock low 5 and high 3 system clocks
// Notes: Released data line reads high through the pull-up
`timescale 1ns/1ps
`default_nettype none
module irs_master_model
(
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // ------------------------------
  // Bus cycles
  // ------------------------------
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_o <= b;
    tick(3);
    scl_o <= 1'b1;
    tick(2);
    r = sda_i;
    tick(1);
    scl_o <= 1'b0;
    tick(2);
  endtask
  task automatic start_c();
    sda_o <= 1'b1;
    tick(3);
    scl_o <= 1'b1;
    tick(3);
    sda_o <= 1'b0;
    tick(3);
    scl_o <= 1'b0;
    tick(2);
  endtask
  task automatic stop_c();
    sda_o <= 1'b0;
    tick(3);
    scl_o <= 1'b1;
    tick(3);
    sda_o <= 1'b1;
    tick(4);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(!ack, r);
  endtask
endmodule // irs_master_model
`default_nettype wire

// file: irs_pkg.sv
// Purpose: Constants and types for the two-wire register access slave
// Assumes: System clock 25 MHz, link clock sampled as an ordinary input
// Notes: Operation
// Operation
// - Every link transfer is built from eight-bit bytes.
// - Data falling while clock high is a start; a new stream begins.
// - After start, shift in seven address bits MSB first, then direction.
// - On address match, pull data low during the ninth clock pulse.
// - On address mismatch, stay idle and release bus until next start.
// - Direction 0 means master writes; direction 1 means master reads.
// - Each byte takes nine clocks: eight data plus one acknowledge.
// - Data changes only while clock low; rising data at clock high stops.
// - Bytes per transaction are unlimited by the protocol.
// - On stop, return to idle and reset pointer to zero.
// - Two address bytes form a ten-bit pointer; upper six bits ignored.
// - Third write byte is value high half, fourth is low half.
// - Pointer advances per written register, never wraps; excess writes dropped.
// - Registers are sixteen bits from two bytes; master sends even counts.
// - Read returns high byte first, then low byte.
// - Read pointer advances per register until master not-acknowledges and stops.
// - At maximum pointer, reads keep returning the last register.
// - Slave address has fixed upper five bits and two pin-selected bits.
// - Device is only a slave and never starts a transfer.

package irs_pkg;

  // ---------------------------------------------------------------
  // Constants
  // ---------------------------------------------------------------
  localparam logic [4:0] IRS_ADDR_FIXED = 5'h0b;
  localparam logic [3:0] IRS_CNT_ZERO = 4'h0;
  localparam logic [3:0] IRS_CNT_ONE = 4'h1;
  localparam logic [3:0] IRS_CNT_ACK = 4'h8;
  localparam logic [3:0] IRS_CNT_END = 4'h9;
  localparam logic [9:0] IRS_PTR_RESET = 10'h000;
  localparam logic [9:0] IRS_PTR_MAX = 10'h3ff;
  localparam logic [9:0] IRS_PTR_STEP = 10'h001;
  localparam logic IRS_DIR_READ = 1'h1;
  localparam logic [1:0] IRS_IDX_PTR_HI = 2'h0;
  localparam logic [1:0] IRS_IDX_PTR_LO = 2'h1;
  localparam logic [1:0] IRS_IDX_DATA_HI = 2'h2;
  localparam logic [1:0] IRS_IDX_DATA_LO = 2'h3;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    IRS_ST_IDLE = 2'b00,
    IRS_ST_ADDR = 2'b01,
    IRS_ST_WRITE = 2'b10,
    IRS_ST_READ = 2'b11
  } irs_state_t;

  typedef struct packed {
    logic [9:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } irs_reg_req_t;

endpackage

// file: irs_slave.sv
// Purpose: Two-wire slave giving a host access to 16-bit registers
// Assumes: Register bank answers reg_rdata_i combinationally from addr
// Notes: Open-drain data pin only ever pulled low

`timescale 1ns/1ps
`default_nettype none

module irs_slave
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic slave_addr_sel_lo,
  input wire logic slave_addr_sel_hi,
  output irs_pkg::irs_reg_req_t reg_req_o,
  input wire logic [15:0] reg_rdata_i,
  output logic busy_o
);

  logic scl_s;
  logic sda_s;
  logic scl_q;
  logic sda_q;
  logic [1:0] sel_meta;
  logic [1:0] sel_sync;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  irs_pkg::irs_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_byte;
  logic dir_read;
  logic addr_match;
  logic [1:0] byte_idx;
  logic half_lo;
  logic [1:0] ptr_hi;
  logic [9:0] ptr;
  logic ptr_end;
  logic [7:0] data_hi;
  logic [15:0] tx_word;
  logic [7:0] tx_byte;
  logic master_ack;
  logic [15:0] wdata;
  logic wr_pulse;
  logic rd_pulse;
  logic ack_cycle;
  logic ack_end;

  // ---------------------------------------------------------------
  // Input synchronisers and edge detection
  // ---------------------------------------------------------------
  irs_sync u_sync_scl
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(scl_i),
    .sync_o(scl_s)
  );

  irs_sync u_sync_sda
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(sda_i),
    .sync_o(sda_s)
  );

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      sel_meta <= 2'h0;
      sel_sync <= 2'h0;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      sel_meta <= {slave_addr_sel_hi, slave_addr_sel_lo};
      sel_sync <= sel_meta;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det = scl_s & scl_q & ~sda_q & sda_s;
  assign ack_cycle = scl_fall & (bit_cnt == irs_pkg::IRS_CNT_ACK);
  assign ack_end = scl_fall & (bit_cnt == irs_pkg::IRS_CNT_END);
  assign addr_match = (rx_byte[7:1] == {irs_pkg::IRS_ADDR_FIXED,
    sel_sync});

  // ---------------------------------------------------------------
  // Transfer state
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      state <= irs_pkg::IRS_ST_IDLE;
    else if (start_det)
      state <= irs_pkg::IRS_ST_ADDR;
    else if (stop_det)
      state <= irs_pkg::IRS_ST_IDLE;
    else
    begin
      case (state)
        irs_pkg::IRS_ST_ADDR:
        begin
          if (ack_cycle && !addr_match)
            state <= irs_pkg::IRS_ST_IDLE;
          else if (ack_end && dir_read == irs_pkg::IRS_DIR_READ)
            state <= irs_pkg::IRS_ST_READ;
          else if (ack_end)
            state <= irs_pkg::IRS_ST_WRITE;
        end
        irs_pkg::IRS_ST_READ:
        begin
          if (ack_end && !master_ack)
            state <= irs_pkg::IRS_ST_IDLE;
        end
        default:
          state <= state;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Bit counter: eight data clocks then the acknowledge clock
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i || start_det || state == irs_pkg::IRS_ST_IDLE)
      bit_cnt <= irs_pkg::IRS_CNT_ZERO;
    else if (ack_end)
      bit_cnt <= irs_pkg::IRS_CNT_ZERO;
    else if (scl_rise)
      bit_cnt <= bit_cnt + irs_pkg::IRS_CNT_ONE;
  end

  // ---------------------------------------------------------------
  // Receive shifter, sampled on the rising clock
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      rx_byte <= 8'h00;
    else if (scl_rise && bit_cnt < irs_pkg::IRS_CNT_ACK)
      rx_byte <= {rx_byte[6:0], sda_s};
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      dir_read <= 1'h0;
    else if (state == irs_pkg::IRS_ST_ADDR && ack_cycle)
      dir_read <= rx_byte[0];
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      master_ack <= 1'h0;
    else if (scl_rise && bit_cnt == irs_pkg::IRS_CNT_ACK)
      master_ack <= ~sda_s;
  end

  // ---------------------------------------------------------------
  // Write byte sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i || state != irs_pkg::IRS_ST_WRITE)
      byte_idx <= irs_pkg::IRS_IDX_PTR_HI;
    else if (ack_cycle && byte_idx == irs_pkg::IRS_IDX_DATA_LO)
      byte_idx <= irs_pkg::IRS_IDX_DATA_HI;
    else if (ack_cycle)
      byte_idx <= byte_idx + 2'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ptr_hi <= 2'h0;
      data_hi <= 8'h00;
    end
    else if (state == irs_pkg::IRS_ST_WRITE && ack_cycle)
    begin
      if (byte_idx == irs_pkg::IRS_IDX_PTR_HI)
        ptr_hi <= rx_byte[1:0];
      if (byte_idx == irs_pkg::IRS_IDX_DATA_HI)
        data_hi <= rx_byte;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wdata <= 16'h0000;
      wr_pulse <= 1'h0;
    end
    else
    begin
      wr_pulse <= 1'h0;
      if (state == irs_pkg::IRS_ST_WRITE && ack_cycle &&
          byte_idx == irs_pkg::IRS_IDX_DATA_LO && !ptr_end)
      begin
        wdata <= {data_hi, rx_byte};
        wr_pulse <= 1'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register pointer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i || stop_det)
    begin
      ptr <= irs_pkg::IRS_PTR_RESET;
      ptr_end <= 1'h0;
    end
    else if (state == irs_pkg::IRS_ST_WRITE && ack_cycle &&
             byte_idx == irs_pkg::IRS_IDX_PTR_LO)
    begin
      ptr <= {ptr_hi, rx_byte};
      ptr_end <= 1'h0;
    end
    else if (wr_pulse ||
             (state == irs_pkg::IRS_ST_READ && half_lo && scl_rise &&
              bit_cnt == irs_pkg::IRS_CNT_ACK && !sda_s))
    begin
      if (ptr == irs_pkg::IRS_PTR_MAX)
        ptr_end <= 1'h1;
      else
        ptr <= ptr + irs_pkg::IRS_PTR_STEP;
    end
  end

  // ---------------------------------------------------------------
  // Read data path
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i || state == irs_pkg::IRS_ST_IDLE)
      half_lo <= 1'h0;
    else if (state == irs_pkg::IRS_ST_READ && ack_end)
      half_lo <= ~half_lo;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tx_word <= 16'h0000;
      tx_byte <= 8'h00;
      rd_pulse <= 1'h0;
    end
    else
    begin
      rd_pulse <= 1'h0;
      if (ack_end && ((state == irs_pkg::IRS_ST_ADDR && dir_read) ||
          (state == irs_pkg::IRS_ST_READ && master_ack && half_lo)))
      begin
        tx_word <= reg_rdata_i;
        tx_byte <= reg_rdata_i[15:8];
        rd_pulse <= 1'h1;
      end
      else if (ack_end && state == irs_pkg::IRS_ST_READ && master_ack)
        tx_byte <= tx_word[7:0];
      else if (scl_fall && state == irs_pkg::IRS_ST_READ &&
               bit_cnt != irs_pkg::IRS_CNT_ZERO &&
               bit_cnt < irs_pkg::IRS_CNT_ACK)
        tx_byte <= {tx_byte[6:0], 1'h0};
    end
  end

  // ---------------------------------------------------------------
  // Open-drain data driver, changed after a falling clock, cleared at once on start or stop
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i || start_det || stop_det)
      sda_oe_o <= 1'h0;
    else if (scl_fall)
    begin
      case (state)
        irs_pkg::IRS_ST_ADDR:
          sda_oe_o <= ack_cycle && addr_match;
        irs_pkg::IRS_ST_WRITE:
          sda_oe_o <= ack_cycle;
        irs_pkg::IRS_ST_READ:
          sda_oe_o <= 1'h0;
        default:
          sda_oe_o <= 1'h0;
      endcase
    end
    else if (state == irs_pkg::IRS_ST_READ && bit_cnt < irs_pkg::IRS_CNT_ACK
             && !scl_s && !scl_q)
      sda_oe_o <= ~tx_byte[7];
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      sda_o <= 1'h0;
    else
      sda_o <= 1'h0;
  end

  // ---------------------------------------------------------------
  // Register bank request and status
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      busy_o <= 1'h0;
    else
      busy_o <= (state != irs_pkg::IRS_ST_IDLE);
  end

  assign reg_req_o = '{addr: ptr, wdata: wdata, wr: wr_pulse, rd: rd_pulse};

endmodule // irs_slave

`default_nettype wire

// file: irs_slave_bench.sv
// Purpose: Self-checking bench for irs_slave
// Assumes: Register bank modelled here, answering at once
// Notes: Link clock period 320 ns
`timescale 1ns/1ps
`default_nettype none
module irs_slave_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sel_lo = 1'b0;
  logic sel_hi = 1'b0;
  wire logic scl;
  wire logic m_sda;
  wire logic sda_oe;
  wire logic sda_d;
  wire logic sda_line;
  wire logic busy;
  irs_pkg::irs_reg_req_t req;
  logic [15:0] regs [1024];
  int err_total = 0;
  int check_count = 0;
  assign sda_line = m_sda & ~(sda_oe & ~sda_d);
  initial
  begin
    forever #20 clk = ~clk;
  end
  irs_slave dut
  (
    .clk_i(clk), .reset_i(reset), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_d), .sda_oe_o(sda_oe), .slave_addr_sel_lo(sel_lo),
    .slave_addr_sel_hi(sel_hi), .reg_req_o(req),
    .reg_rdata_i(regs[req.addr]), .busy_o(busy)
  );
  irs_master_model m
  (
    .clk_i(clk), .sda_i(sda_line), .scl_o(scl), .sda_o(m_sda)
  );
  always @(posedge clk) if (req.wr) regs[req.addr] <= req.wdata;
  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic summarize();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] dev(input logic rd);
    return {5'h0b, sel_hi, sel_lo, rd};
  endfunction
  task automatic wb(input logic [7:0] d, input logic e);
    logic a;
    m.wbyte(d, a);
    chk({15'h0000, a}, {15'h0000, e});
  endtask
  task automatic rw(input logic [15:0] e, input logic last);
    logic [7:0] h;
    logic [7:0] l;
    m.rbyte(h, 1'b1);
    m.rbyte(l, !last);
    chk({h, l}, e);
  endtask
  task automatic setp(input logic [9:0] p);
    m.start_c();
    wb(dev(1'b0), 1'b1);
    chk({15'h0000, busy}, 16'h0001);
    wb({6'h3f, p[9:8]}, 1'b1);
    wb(p[7:0], 1'b1);
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_write();
    setp(10'h012);
    wb(8'hab, 1'b1);
    wb(8'hcd, 1'b1);
    wb(8'h12, 1'b1);
    wb(8'h34, 1'b1);
    m.stop_c();
    chk(regs[18], 16'habcd);
    chk(regs[19], 16'h1234);
  endtask
  task automatic t_read();
    setp(10'h012);
    m.start_c();
    wb(dev(1'b1), 1'b1);
    rw(16'habcd, 1'b0);
    rw(16'h1234, 1'b1);
    m.stop_c();
  endtask
  task automatic t_stop_ptr();
    m.start_c();
    wb(dev(1'b1), 1'b1);
    rw(16'h5a5a, 1'b1);
    m.stop_c();
  endtask
  task automatic t_strap();
    for (int s = 0; s < 4; s++)
    begin
      sel_hi <= s[1];
      sel_lo <= s[0];
      m.tick(4);
      m.start_c();
      wb({5'h0b, ~s[1], s[0], 1'b0}, 1'b0);
      wb(8'h00, 1'b0);
      chk({15'h0000, busy}, 16'h0000);
      m.stop_c();
      m.start_c();
      wb(dev(1'b0), 1'b1);
      m.stop_c();
    end
  endtask
  task automatic t_max();
    setp(10'h3ff);
    wb(8'h11, 1'b1);
    wb(8'h11, 1'b1);
    wb(8'h22, 1'b1);
    wb(8'h22, 1'b1);
    m.start_c();
    wb(dev(1'b1), 1'b1);
    rw(16'h1111, 1'b0);
    rw(16'h1111, 1'b0);
    rw(16'h1111, 1'b1);
    m.stop_c();
    chk(regs[1023], 16'h1111);
  endtask
  // ------------------------------
  // Run
  // ------------------------------
  initial
  begin
    for (int i = 0; i < 1024; i++) regs[i] = 16'h0000;
    regs[0] = 16'h5a5a;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    m.tick(8);
    t_write();
    t_read();
    t_stop_ptr();
    t_strap();
    t_max();
    summarize();
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule // irs_slave_bench
`default_nettype wire

// file: irs_slave_properties.sv
// Purpose: Port checker for the two-wire register access slave
// Assumes: Bound to irs_slave, one clock domain
// Notes: Bind statement follows the module
`timescale 1ns/1ps
`default_nettype none
module irs_slave_properties
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire irs_pkg::irs_reg_req_t reg_req_o,
  input wire logic busy_o
);
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  a_reset_quiet: assert property ($fell(reset_i) |->
    !sda_oe_o && !busy_o && reg_req_o.addr == 10'h000)
    else $error("outputs active after reset");
  a_drive_low: assert property (sda_oe_o |-> !sda_o)
    else $error("data pin driven high");
  a_oe_stands: assert property ($rose(sda_oe_o) |=> sda_oe_o [*6])
    else $error("data drive released early");
  a_oe_clk_low: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 2))
    else $error("data drive changed with clock high");
  a_wr_single: assert property (reg_req_o.wr |=> !reg_req_o.wr)
    else $error("write pulse too long");
  a_wr_busy: assert property (reg_req_o.wr |-> busy_o)
    else $error("write outside a transfer");
  a_ptr_step: assert property (
    reg_req_o.wr && reg_req_o.addr != 10'h3ff |=>
    reg_req_o.addr == $past(reg_req_o.addr) + 10'h001)
    else $error("pointer did not advance by one");
  a_ptr_hold: assert property (
    reg_req_o.addr == 10'h3ff |=> reg_req_o.addr inside {10'h3ff, 10'h000})
    else $error("pointer wrapped");
  a_stop_idle: assert property (
    $rose(sda_i) && scl_i && $past(scl_i) |-> ##[2:8]
    (reg_req_o.addr == 10'h000 && !busy_o && !sda_oe_o))
    else $error("no idle after stop");
  a_rd_single: assert property (reg_req_o.rd |=> !reg_req_o.rd)
    else $error("read pulse too long");
endmodule // irs_slave_properties
bind irs_slave irs_slave_properties u_props
(
  .clk_i, .reset_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .reg_req_o, .busy_o
);
`default_nettype wire

// file: irs_sync.sv
// Purpose: Two flip-flop synchroniser for one asynchronous input
// Assumes: Input comes from outside the clk_i domain
// Notes: Only the second stage leaves this module

`timescale 1ns/1ps
`default_nettype none

module irs_sync
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic async_i,
  output logic sync_o
);

  logic stage1;

  // ---------------------------------------------------------------
  // Two stage capture, idle level high
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      stage1 <= 1'h1;
      sync_o <= 1'h1;
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule // irs_sync

`default_nettype wire
